// ### src/tlrg_control.sv
`timescale 1ns/1ps
`default_nettype none

module tlrg_control #(
  parameter int unsigned SETTLE_CYCLES     = tlrg_pkg::SETTLE_CYCLES,
  parameter int unsigned RECORD_GAP_CYCLES = tlrg_pkg::RECORD_GAP_CYCLES,
  parameter int unsigned FILE_GAP_CYCLES   = tlrg_pkg::FILE_GAP_CYCLES,
  parameter int unsigned DELAY_CYCLES      = tlrg_pkg::DELAY_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic panelLoadN,
  input  wire logic hostLoadN,
  input  wire logic panelRewindN,
  input  wire logic hostRewindN,
  input  wire logic recordSelect,
  input  wire logic tapeStartMarker,
  input  wire logic brokenTape,
  input  wire logic recordGapCmd,
  output logic      forwardRelay,
  output logic      forwardLampN,
  output logic      rewindRelay,
  output logic      rewindLamp,
  output logic      brokenTapeN,
  output logic      recordArmed,
  output logic      headSupplyEn,
  output logic      tapeOrigin,
  output logic      stepOscillatorRequestN,
  output logic      checkHoldN,
  output logic      gapActiveFlagN,
  output logic      gapActiveFlag
);

  localparam int unsigned NIN = 8;
  localparam logic [NIN-1:0] SYNC_IDLE = 8'h0f;

  // Two-stage synchronisers for every outside input
  logic [NIN-1:0] rawIn;
  logic [NIN-1:0] meta_q;
  logic [NIN-1:0] sync_q;
  logic [NIN-1:0] prev_q;

  assign rawIn = {recordGapCmd, brokenTape, tapeStartMarker, recordSelect,
                  hostRewindN, panelRewindN, hostLoadN, panelLoadN};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (reset) begin
          // Active-low commands idle high, so their stages reset high
          meta_q[gi] <= SYNC_IDLE[gi];
          sync_q[gi] <= SYNC_IDLE[gi];
          prev_q[gi] <= SYNC_IDLE[gi];
        end else begin
          meta_q[gi] <= rawIn[gi];
          sync_q[gi] <= meta_q[gi];
          prev_q[gi] <= sync_q[gi];
        end
      end
    end
  endgenerate

  function automatic logic fallEdge(input logic cur, input logic prev);
    return prev & ~cur;
  endfunction

  logic loadCmd;
  logic loadIdle;
  logic rewindCmd;
  logic markerS;
  logic markerRise;
  logic brokenS;
  logic selectS;
  logic gapCmdRise;

  // Stages reset to each pin's idle level, so no false edge follows reset;
  // a load held low through reset gives its one edge during settling and is refused.
  assign loadCmd    = fallEdge(sync_q[0], prev_q[0]) | fallEdge(sync_q[1], prev_q[1]);
  assign loadIdle   = sync_q[0] & sync_q[1];
  assign rewindCmd  = fallEdge(sync_q[2], prev_q[2]) | fallEdge(sync_q[3], prev_q[3]);
  assign selectS    = sync_q[4];
  assign markerS    = sync_q[5];
  assign markerRise = sync_q[5] & ~prev_q[5];
  assign brokenS    = sync_q[6];
  assign gapCmdRise = sync_q[7] & ~prev_q[7];

  // Power-up settling counter
  logic [tlrg_pkg::CNT_W-1:0] settle_q;
  logic settled;
  assign settled = (settle_q == tlrg_pkg::CNT_W'(SETTLE_CYCLES));

  always_ff @(posedge clk) begin
    if (reset) begin
      settle_q <= '0;
    end else if (!settled) begin
      settle_q <= settle_q + 1'b1;
    end
  end

  logic advance_q;
  logic ready_q;
  logic rewind_q;
  logic advanceClear;

  // Start marker during rewind ends rewind
  assign advanceClear = brokenS | (rewind_q & markerS);

  always_ff @(posedge clk) begin
    if (reset) begin
      advance_q <= 1'b0;
    end else if (!settled || advanceClear) begin
      advance_q <= 1'b0;
    end else if (loadCmd) begin
      advance_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !advance_q || advanceClear) begin
      rewind_q <= 1'b0;
    end else if (rewindCmd) begin
      rewind_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || !advance_q || advanceClear || rewind_q || rewindCmd) begin
      ready_q <= 1'b0;
    end else if (markerRise || markerS) begin
      ready_q <= 1'b1;
    end
  end

  // Loading request: held from load until ready and load released
  logic loadRun_q;
  always_ff @(posedge clk) begin
    if (reset || !advance_q || rewind_q || advanceClear) begin
      loadRun_q <= 1'b0;
    end else if (!ready_q) begin
      loadRun_q <= 1'b1;
    end else if (loadIdle) begin
      loadRun_q <= 1'b0;
    end
  end

  logic armed;
  assign armed = ready_q & selectS;

  // Gap sequencer
  tlrg_pkg::tlrg_gap_t gap_q;
  logic [tlrg_pkg::CNT_W-1:0] gapCnt_q;
  logic startSeq_q;
  logic gapRun_q;
  logic recGap;
  logic startTrig;
  logic gapDone;

  assign recGap    = (gap_q == tlrg_pkg::TLRG_GAP_REC);
  assign startTrig = armed & markerS & ~startSeq_q;
  assign gapDone   = (gapCnt_q == '0);

  always_ff @(posedge clk) begin
    if (reset || !markerS || !armed) begin
      startSeq_q <= 1'b0;
    end else if (startTrig) begin
      startSeq_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || brokenS) begin
      gap_q    <= tlrg_pkg::TLRG_GAP_IDLE;
      gapCnt_q <= '0;
    end else begin
      case (gap_q)
        tlrg_pkg::TLRG_GAP_IDLE: begin
          if (startTrig) begin
            gap_q    <= tlrg_pkg::TLRG_GAP_FILE;
            gapCnt_q <= tlrg_pkg::CNT_W'(FILE_GAP_CYCLES - 1);
          end else if (gapCmdRise) begin
            gap_q    <= tlrg_pkg::TLRG_GAP_REC;
            gapCnt_q <= tlrg_pkg::CNT_W'(RECORD_GAP_CYCLES - 1);
          end
        end
        tlrg_pkg::TLRG_GAP_FILE: begin
          if (gapDone) begin
            gap_q    <= tlrg_pkg::TLRG_GAP_REC;
            gapCnt_q <= tlrg_pkg::CNT_W'(RECORD_GAP_CYCLES - 1);
          end else begin
            gapCnt_q <= gapCnt_q - 1'b1;
          end
        end
        tlrg_pkg::TLRG_GAP_REC: begin
          if (gapDone) begin
            gap_q    <= tlrg_pkg::TLRG_GAP_DELAY;
            gapCnt_q <= tlrg_pkg::CNT_W'(DELAY_CYCLES - 1);
          end else begin
            gapCnt_q <= gapCnt_q - 1'b1;
          end
        end
        tlrg_pkg::TLRG_GAP_DELAY: begin
          if (gapDone) begin
            gap_q <= tlrg_pkg::TLRG_GAP_IDLE;
          end else begin
            gapCnt_q <= gapCnt_q - 1'b1;
          end
        end
        default: begin
          gap_q    <= tlrg_pkg::TLRG_GAP_IDLE;
          gapCnt_q <= '0;
        end
      endcase
    end
  end

  // Gap-run follows the gap latch through file and record gap phases
  always_ff @(posedge clk) begin
    if (reset || brokenS) begin
      gapRun_q <= 1'b0;
    end else begin
      gapRun_q <= (gap_q == tlrg_pkg::TLRG_GAP_FILE) || recGap;
    end
  end

  logic gapOsc;
  logic oscReq;
  assign gapOsc = gapRun_q & armed;
  // Rewind or broken tape override every source of the request
  assign oscReq = (loadRun_q | gapOsc) & ~rewind_q & ~brokenS;

  always_ff @(posedge clk) begin
    if (reset) begin
      forwardRelay           <= 1'b0;
      forwardLampN           <= 1'b1;
      rewindRelay            <= 1'b0;
      rewindLamp             <= 1'b0;
      brokenTapeN            <= 1'b1;
      recordArmed            <= 1'b0;
      headSupplyEn           <= 1'b0;
      tapeOrigin             <= 1'b0;
      stepOscillatorRequestN <= 1'b1;
      checkHoldN             <= 1'b1;
      gapActiveFlagN         <= 1'b1;
      gapActiveFlag          <= 1'b0;
    end else begin
      forwardRelay           <= advance_q;
      forwardLampN           <= ~advance_q;
      rewindRelay            <= rewind_q;
      rewindLamp             <= rewind_q;
      brokenTapeN            <= ~brokenS;
      recordArmed            <= armed;
      headSupplyEn           <= armed;
      tapeOrigin             <= markerS;
      stepOscillatorRequestN <= ~oscReq;
      checkHoldN             <= ~recGap;
      gapActiveFlagN         <= ~(gapOsc | (gap_q == tlrg_pkg::TLRG_GAP_DELAY));
      gapActiveFlag          <= gapOsc | (gap_q == tlrg_pkg::TLRG_GAP_DELAY);
    end
  end

  sequence s_recEnter;
    gap_q == tlrg_pkg::TLRG_GAP_REC;
  endsequence

  // Outputs lag the latches by one edge, so output checks look one cycle on
  a_reset_clears: assert property (@(posedge clk)
    reset |=> !advance_q && !ready_q && !rewind_q)
    else $error("latches not cleared by reset");
  a_settle_hold: assert property (@(posedge clk) disable iff (reset)
    !settled |=> !advance_q)
    else $error("advance set during settling");
  a_load_sets: assert property (@(posedge clk) disable iff (reset)
    settled && loadCmd && !advanceClear |=> advance_q ##1 forwardRelay && !forwardLampN)
    else $error("load did not set advance");
  a_load_run: assert property (@(posedge clk) disable iff (reset)
    advance_q && !ready_q && !rewind_q && !advanceClear |=> loadRun_q)
    else $error("loading request missing");
  a_load_release: assert property (@(posedge clk) disable iff (reset)
    ready_q && loadIdle |=> !loadRun_q)
    else $error("loading request held after release");
  a_armed_out: assert property (@(posedge clk) disable iff (reset)
    ready_q && selectS |=> recordArmed && headSupplyEn)
    else $error("record-armed missing");
  a_broken_clears: assert property (@(posedge clk) disable iff (reset)
    brokenS |=> !advance_q && !rewind_q && !ready_q && !brokenTapeN && stepOscillatorRequestN)
    else $error("broken tape not handled");
  a_rewind_sets: assert property (@(posedge clk) disable iff (reset)
    advance_q && !advanceClear && rewindCmd |=> rewind_q && !ready_q)
    else $error("rewind did not set");
  a_rewind_noosc: assert property (@(posedge clk) disable iff (reset)
    rewind_q |=> stepOscillatorRequestN && rewindRelay)
    else $error("oscillator run while rewinding");
  a_origin_out: assert property (@(posedge clk) disable iff (reset)
    markerS |=> tapeOrigin)
    else $error("tape origin missing");

  a_gap_start: assert property (@(posedge clk) disable iff (reset || brokenS)
    gap_q == tlrg_pkg::TLRG_GAP_IDLE && gapCmdRise && !startTrig |=> recGap)
    else $error("record gap not started");
  a_gap_length: assert property (@(posedge clk) disable iff (reset || brokenS)
    (gap_q == tlrg_pkg::TLRG_GAP_IDLE) ##1 s_recEnter |-> s_recEnter [*2])
    else $error("record gap too short");
  a_hold_out: assert property (@(posedge clk) disable iff (reset)
    recGap |=> !checkHoldN)
    else $error("check hold missing");
  a_gap_unarmed: assert property (@(posedge clk) disable iff (reset)
    gapRun_q && !armed && !loadRun_q |=> stepOscillatorRequestN)
    else $error("gap stepping while not armed");
  a_delay_flag: assert property (@(posedge clk) disable iff (reset)
    gap_q == tlrg_pkg::TLRG_GAP_DELAY |=> gapActiveFlag && !gapActiveFlagN)
    else $error("gap active dropped in delay");
  a_delay_release: assert property (@(posedge clk) disable iff (reset)
    gap_q == tlrg_pkg::TLRG_GAP_DELAY && !gapRun_q && !loadRun_q |=> stepOscillatorRequestN)
    else $error("oscillator held in delay");
  a_start_seq: assert property (@(posedge clk) disable iff (reset || brokenS)
    startTrig && gap_q == tlrg_pkg::TLRG_GAP_IDLE |=> gap_q == tlrg_pkg::TLRG_GAP_FILE)
    else $error("tape start gap not begun");

endmodule

`default_nettype wire

// ### src/tlrg_pkg.sv
`default_nettype none
package tlrg_pkg;
  // Clock
  localparam int unsigned CLK_HZ          = 10_000_000;
  // Settling interval after power-up, in microseconds
  localparam int unsigned SETTLE_US       = 1000;
  localparam int unsigned SETTLE_CYCLES   = (SETTLE_US * (CLK_HZ / 1_000_000));
  // Gap stepping rate, steps per second
  localparam int unsigned GAP_STEP_HZ     = 1000;
  // Record gap length, in gap steps
  localparam int unsigned RECORD_GAP_STEPS = 60;
  localparam int unsigned RECORD_GAP_CYCLES = RECORD_GAP_STEPS * (CLK_HZ / GAP_STEP_HZ);
  // File gap length, in gap steps
  localparam int unsigned FILE_GAP_STEPS  = 350;
  localparam int unsigned FILE_GAP_CYCLES = FILE_GAP_STEPS * (CLK_HZ / GAP_STEP_HZ);
  // Stepper recovery delay, in microseconds
  localparam int unsigned DELAY_US        = 20_000;
  localparam int unsigned DELAY_CYCLES    = DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W           = 32;

  typedef enum logic [1:0] {
    TLRG_GAP_IDLE  = 2'b00,
    TLRG_GAP_FILE  = 2'b01,
    TLRG_GAP_REC   = 2'b10,
    TLRG_GAP_DELAY = 2'b11
  } tlrg_gap_t;
endpackage
`default_nettype wire

// ### testbench/tlrg_tape_model.sv
`timescale 1ns/1ps
`default_nettype none
module tlrg_tape_model (
  input  wire logic clk,
  input  wire logic forwardRelay,
  input  wire logic rewindRelay,
  input  wire logic stepOscillatorRequestN,
  output logic      tapeStartMarker
);
  // One step per clock stands in for gap stepping, keeping runs short
  int pos = 0;
  always @(negedge clk) begin
    if (rewindRelay && pos > 0) begin
      pos <= pos - 1;
    end else if (forwardRelay && !stepOscillatorRequestN) begin
      pos <= pos + 1;
    end
  end
  // Marker seen over a short stretch of tape only
  assign tapeStartMarker = (pos >= 40) && (pos < 48);
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, reset, panelLoadN, hostLoadN, panelRewindN, hostRewindN;
  logic recordSelect, tapeStartMarker, brokenTape, recordGapCmd;
  logic forwardRelay, forwardLampN, rewindRelay, rewindLamp, brokenTapeN;
  logic recordArmed, headSupplyEn, tapeOrigin, stepOscillatorRequestN;
  logic checkHoldN, gapActiveFlagN, gapActiveFlag;
  int   fails = 0, checked = 0, cyc = 0, n;

  tlrg_control #(.SETTLE_CYCLES(8), .RECORD_GAP_CYCLES(20), .FILE_GAP_CYCLES(50),
    .DELAY_CYCLES(10)) dut_u (.clk(clk), .reset(reset), .panelLoadN(panelLoadN),
    .hostLoadN(hostLoadN), .panelRewindN(panelRewindN), .hostRewindN(hostRewindN),
    .recordSelect(recordSelect), .tapeStartMarker(tapeStartMarker),
    .brokenTape(brokenTape), .recordGapCmd(recordGapCmd), .forwardRelay(forwardRelay),
    .forwardLampN(forwardLampN), .rewindRelay(rewindRelay), .rewindLamp(rewindLamp),
    .brokenTapeN(brokenTapeN), .recordArmed(recordArmed), .headSupplyEn(headSupplyEn),
    .tapeOrigin(tapeOrigin), .stepOscillatorRequestN(stepOscillatorRequestN),
    .checkHoldN(checkHoldN), .gapActiveFlagN(gapActiveFlagN),
    .gapActiveFlag(gapActiveFlag));

  tlrg_tape_model model_u (.clk(clk), .forwardRelay(forwardRelay),
    .rewindRelay(rewindRelay), .stepOscillatorRequestN(stepOscillatorRequestN),
    .tapeStartMarker(tapeStartMarker));

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task close_out();
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      close_out();
    end
  end

  task chk(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic waitv(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge clk);
      n++;
      #1;
    end
    chk(s, v);
  endtask

  task cycles(input int k);
    repeat (k) @(negedge clk);
  endtask

  task t_settle();
    panelLoadN = 1'h0;
    cycles(6);
    chk(forwardRelay, 1'h0);
    panelLoadN = 1'h1;
    cycles(6);
  endtask

  task t_load();
    panelLoadN = 1'h0;
    waitv(forwardRelay, 1'h1, 8);
    chk(forwardLampN, 1'h0);
    waitv(stepOscillatorRequestN, 1'h0, 3);
    waitv(tapeOrigin, 1'h1, 60);
    cycles(12);
    chk(tapeOrigin, 1'h0);
    chk(stepOscillatorRequestN, 1'h0);
    cycles(1);
    panelLoadN = 1'h1;
    waitv(stepOscillatorRequestN, 1'h1, 8);
    cycles(1);
    recordSelect = 1'h1;
    waitv(recordArmed, 1'h1, 6);
    chk(headSupplyEn, 1'h1);
  endtask

  task t_rewind();
    cycles(1);
    panelRewindN = 1'h0;
    waitv(rewindRelay, 1'h1, 8);
    chk(rewindLamp, 1'h1);
    cycles(1);
    chk(recordArmed, 1'h0);
    chk(stepOscillatorRequestN, 1'h1);
    panelRewindN = 1'h1;
    waitv(rewindRelay, 1'h0, 200);
    chk(forwardRelay, 1'h0);
    chk(tapeOrigin, 1'h1);
  endtask

  // Record gap tail, then the recovery delay
  task rec_tail();
    chk(stepOscillatorRequestN, 1'h0);
    waitv(checkHoldN, 1'h1, 25);
    chk(n >= 19 && n <= 21, 1'h1);
    cycles(2);
    chk(stepOscillatorRequestN, 1'h1);
    chk(gapActiveFlag, 1'h1);
    waitv(gapActiveFlag, 1'h0, 15);
    chk(n >= 6, 1'h1);
    chk(gapActiveFlagN, 1'h1);
  endtask

  task t_start_gap();
    cycles(2);
    hostLoadN = 1'h0;
    cycles(3);
    hostLoadN = 1'h1;
    waitv(recordArmed, 1'h1, 10);
    waitv(gapActiveFlag, 1'h1, 6);
    chk(gapActiveFlagN, 1'h0);
    cycles(20);
    chk(stepOscillatorRequestN, 1'h0);
    chk(checkHoldN, 1'h1);
    waitv(checkHoldN, 1'h0, 40);
    rec_tail();
  endtask

  task t_rec_gap();
    cycles(2);
    recordGapCmd = 1'h1;
    cycles(1);
    recordGapCmd = 1'h0;
    waitv(checkHoldN, 1'h0, 6);
    waitv(gapActiveFlag, 1'h1, 3);
    rec_tail();
    cycles(1);
    recordSelect = 1'h0;
    waitv(recordArmed, 1'h0, 6);
    cycles(1);
    recordGapCmd = 1'h1;
    cycles(1);
    recordGapCmd = 1'h0;
    waitv(checkHoldN, 1'h0, 6);
    chk(stepOscillatorRequestN, 1'h1);
    waitv(checkHoldN, 1'h1, 25);
    cycles(15);
  endtask

  task t_broken();
    hostRewindN = 1'h0;
    waitv(rewindRelay, 1'h1, 8);
    cycles(1);
    hostRewindN = 1'h1;
    cycles(2);
    brokenTape = 1'h1;
    waitv(brokenTapeN, 1'h0, 6);
    waitv(rewindRelay, 1'h0, 4);
    chk(forwardRelay, 1'h0);
    chk(stepOscillatorRequestN, 1'h1);
    cycles(1);
    hostLoadN = 1'h0;
    cycles(8);
    chk(forwardRelay, 1'h0);
    hostLoadN = 1'h1;
    brokenTape = 1'h0;
    waitv(brokenTapeN, 1'h1, 6);
  endtask

  initial begin
    {panelLoadN, hostLoadN, panelRewindN, hostRewindN} = 4'hf;
    {recordSelect, brokenTape, recordGapCmd} = 3'h0;
    reset = 1'h1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(forwardRelay, 1'h0);
    chk(rewindRelay, 1'h0);
    chk(forwardLampN, 1'h1);
    chk(stepOscillatorRequestN, 1'h1);
    chk(gapActiveFlag, 1'h0);
    reset = 1'h0;
    t_settle();
    t_load();
    t_rewind();
    t_start_gap();
    t_rec_gap();
    t_broken();
    close_out();
  end
endmodule
`default_nettype wire
